// File: tb/emb_mem_model.sv
// behavioural external program memory, data memory and address latch
// assumes the bench resolves the multiplexed port level from both sides
`timescale 1ns/1ps
module emb_mem_model (
  // clock for the idle pattern
  input  wire logic        clock_in,
  // strobes from the device
  input  wire logic        ale_in,
  input  wire logic        fetch_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  // bus levels
  input  wire logic [7:0]  port_lvl_in,
  input  wire logic [7:0]  upper_in,
  // drive back and latch contents
  output logic      [7:0]  drive_out,
  output logic      [15:0] latched_out
);
  // =========================================================
  // storage
  logic [7:0] ram [0:65535];   // data space, apart from program space
  logic [7:0] junk = 8'h3c;    // changes every cycle while released

  // program bytes made from the address, so no table is needed
  function automatic logic [7:0] rom(input logic [15:0] a);
    return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5a;
  endfunction

  // =========================================================
  // latch takes the low byte as the strobe falls
  always @(negedge ale_in) latched_out = {upper_in, port_lvl_in};

  // write byte taken as the write strobe ends
  always @(posedge wr_n_in) ram[latched_out] = port_lvl_in;

  // released port shows a moving pattern, never the last byte
  always @(posedge clock_in) junk <= junk + 8'h3b;

  // answer onto the port while enabled
  always_comb begin
    if (!fetch_n_in) begin
      drive_out = rom(latched_out);
    end else if (!rd_n_in) begin
      drive_out = ram[latched_out];
    end else begin
      drive_out = junk;
    end
  end
endmodule

// File: tb/tb.sv
// self-checking bench of the external memory bus sequencer
// assumes a 50 MHz clock and a behavioural memory on the far side
`timescale 1ns/1ps
module tb;
  // =========================================================
  // stimulus, driven at the falling edge
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        req_valid = 1'b0;
  logic [1:0]  req_kind  = 2'h0;
  logic [15:0] req_addr  = 16'h0;
  logic [7:0]  req_wdata = 8'h0;
  logic [7:0]  gpio_out  = 8'h0;
  logic [7:0]  gpio_oe   = 8'h0;
  logic        strap_n   = 1'b0;   // held low by the board
  // observed pins
  logic        ack, rsp_valid, p0_oe, ale, ale_oe, fetch_n, fetch_oe, wr_n, rd_n, fault;
  logic [7:0]  rsp_data, p0_out, p2_out, p2_oe, mdl_drive, p0_lvl;
  logic [15:0] latched;
  logic        ale_d = 1'b1;
  int          fail_count = 0;
  int          num_checks = 0;
  int          ale_rises, fetch_low, rd_low, wr_low;

  // port level: the device wins while it drives
  assign p0_lvl = p0_oe ? p0_out : mdl_drive;

  always #10 clock_in = ~clock_in;

  emb_bus dut (.clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_kind_in(req_kind), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ack_out(ack), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .gpio_out_in(gpio_out), .gpio_oe_in(gpio_oe), .muxed_addr_data_port_in(p0_lvl),
    .muxed_addr_data_port_out(p0_out), .muxed_addr_data_port_oe_out(p0_oe),
    .upper_address_port_out(p2_out), .upper_address_port_oe_out(p2_oe),
    .addr_latch_out(ale), .addr_latch_oe_out(ale_oe),
    .program_fetch_enable_n_out(fetch_n), .program_fetch_enable_oe_out(fetch_oe),
    .data_write_n_out(wr_n), .data_read_n_out(rd_n),
    .external_program_select_n_in(strap_n), .program_select_fault_out(fault));

  emb_mem_model mem (.clock_in(clock_in), .ale_in(ale), .fetch_n_in(fetch_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .port_lvl_in(p0_lvl), .upper_in(p2_out),
    .drive_out(mdl_drive), .latched_out(latched));

  // =========================================================
  // pin activity counters, one sample per cycle
  always @(posedge clock_in) begin
    if (ale === 1'b1 && ale_d === 1'b0) ale_rises++;
    if (fetch_n === 1'b0) fetch_low++;
    if (rd_n === 1'b0) rd_low++;
    if (wr_n === 1'b0) wr_low++;
    ale_d = ale;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =========================================================
  // reset: pins released to their pull-ups, then driven again
  task automatic t_reset();
    @(negedge clock_in);
    rst_in = 1'b1;
    repeat (24) @(negedge clock_in);  // two machine cycles
    check(ale_oe, 1'b0);
    check(ale, 1'b1);
    check(fetch_oe, 1'b0);
    check(fetch_n, 1'b1);
    check({p0_oe, rd_n, wr_n}, 3'h3);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    check({ale_oe, fetch_oe}, 2'h3);
  endtask

  // one access with every pin relation judged against its kind
  task automatic access(input logic [1:0] kind, input logic [15:0] addr,
                        input logic [7:0] wd, input logic [7:0] exp);
    int         n;
    int         len;
    int         rsp_at;
    logic [7:0] hi, hi_oe, lo, got;
    len = kind[1] ? 12 : 6;
    rsp_at = -1;
    @(negedge clock_in);
    req_valid = 1'b1;
    req_kind = kind;
    req_addr = addr;
    req_wdata = wd;
    n = 0;
    while (ack !== 1'b1 && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    req_valid = 1'b0;
    check(n < 20, 1'b1);
    ale_rises = 0;
    fetch_low = 0;
    rd_low = 0;
    wr_low = 0;
    lo = p0_out;
    for (int i = 1; i <= len; i++) begin
      @(negedge clock_in);
      if (i == 1) begin
        hi = p2_out;
        hi_oe = p2_oe;
      end
      if (i == 7 && kind == 2'b11) lo = p0_out;  // write byte replaces address
      if (rsp_valid === 1'b1) begin
        rsp_at = i;
        got = rsp_data;
      end
    end
    check(lo, (kind == 2'b11) ? wd : addr[7:0]);
    check({hi, hi_oe}, {addr[15:8], 8'hff});
    check(latched, addr);
    check(ale_rises, 1);
    check(fetch_low, kind[1] ? 0 : 2);
    check({rd_low[3:0], wr_low[3:0]}, (kind == 2'b10) ? 8'h40 : (kind == 2'b11) ? 8'h04 : 8'h00);
    check(rsp_at, (kind == 2'b11) ? -1 : len - 1);
    if (kind != 2'b11) check(got, exp);
  endtask

  // idle slots: regular strobe, upper port back to general use
  task automatic t_idle();
    @(negedge clock_in);
    gpio_out = 8'ha5;
    gpio_oe = 8'h3c;
    ale_rises = 0;
    fetch_low = 0;
    repeat (60) @(negedge clock_in);
    check(ale_rises, 10);
    check(fetch_low, 0);
    check({p2_out, p2_oe}, 16'ha53c);
  endtask

  // strap wrongly high is reported, low again clears it
  task automatic t_strap();
    @(negedge clock_in);
    strap_n = 1'b1;
    repeat (3) @(negedge clock_in);
    check(fault, 1'b1);
    strap_n = 1'b0;
    repeat (3) @(negedge clock_in);
    check(fault, 1'b0);
  endtask

  // =========================================================
  // main sequence
  initial begin
    t_reset();
    t_idle();
    access(2'b00, 16'h0000, 8'h00, mem.rom(16'h0000));
    access(2'b01, 16'hffff, 8'h00, mem.rom(16'hffff));
    access(2'b11, 16'h1234, 8'h9e, 8'h00);
    access(2'b11, 16'hffff, 8'h01, 8'h00);
    access(2'b10, 16'h1234, 8'h00, 8'h9e);
    access(2'b10, 16'hffff, 8'h00, 8'h01);
    access(2'b00, 16'h1234, 8'h00, mem.rom(16'h1234));
    t_strap();
    t_reset();
    access(2'b01, 16'h8001, 8'h00, mem.rom(16'h8001));
    stop_test();
  end

  // watchdog, about eight times the expected run
  initial begin
    repeat (2000) @(posedge clock_in);
    fail_count++;
    stop_test();
  end
endmodule

// File: verilog/emb_bus.sv
// external memory bus sequencer: latch strobe, program enable, strobes
// assumes a core that holds its request until it sees the acknowledge,
// and board pull-ups on the latch strobe and program enable pins
`timescale 1ns/1ps

// Overview of operation
// R01 - low address and data share one port
// R02 - upper address driven on second port
// R03 - latch strobe every six oscillator clocks
// R04 - one latch pulse skipped per data access
// R05 - latch strobe released to pull-up in reset
// R06 - program enable low for fetch, table reads
// R07 - program enable released to pull-up in reset
// R08 - program select input held low by system
// R09 - reset held at least two machine cycles
// R10 - write and read strobes on port three
// R11 - separate 64K program and data spaces
// R12 - latch captures address on strobe fall
module emb_bus (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // core request
  input  wire logic        req_valid_in,
  input  wire logic [1:0]  req_kind_in,
  input  wire logic [15:0] req_addr_in,
  input  wire logic [7:0]  req_wdata_in,
  output logic             req_ack_out,
  // core answer
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_data_out,
  // general use of the upper port when no access runs
  input  wire logic [7:0]  gpio_out_in,
  input  wire logic [7:0]  gpio_oe_in,
  // multiplexed port
  input  wire logic [7:0]  muxed_addr_data_port_in,
  output logic [7:0]       muxed_addr_data_port_out,
  output logic             muxed_addr_data_port_oe_out,
  // upper address port
  output logic [7:0]       upper_address_port_out,
  output logic [7:0]       upper_address_port_oe_out,
  // control pins
  output logic             addr_latch_out,
  output logic             addr_latch_oe_out,
  output logic             program_fetch_enable_n_out,
  output logic             program_fetch_enable_oe_out,
  output logic             data_write_n_out,
  output logic             data_read_n_out,
  // strap monitor
  input  wire logic        external_program_select_n_in,
  output logic             program_select_fault_out
);

  // =========================================================
  // slot divider
  emb_slot_if slot ();  // phase carrier

  emb_slot_timer u_timer (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .slot     (slot)
  );

  logic [2:0] ph_nxt;  // phase the pins will show next
  assign ph_nxt = slot.last ? emb_pkg::PH_FIRST : (slot.phase + 3'h1);

  // =========================================================
  // access state
  emb_pkg::emb_state_e state_r,  state_nxt;  // slot kind
  emb_pkg::emb_kind_e  kind_r,   kind_nxt;   // current access kind
  logic                op_r,     op_nxt;     // slot carries an access
  logic [15:0]         addr_r,   addr_nxt;   // 16-bit address
  logic [7:0]          wdata_r,  wdata_nxt;  // write byte
  // pin and answer registers
  logic       ack_r,   ack_nxt;
  logic       rspv_r,  rspv_nxt;
  logic [7:0] rspd_r,  rspd_nxt;
  logic [7:0] p0_r,    p0_nxt;
  logic       p0oe_r,  p0oe_nxt;
  logic [7:0] p2_r,    p2_nxt;
  logic [7:0] p2oe_r,  p2oe_nxt;
  logic       ale_r,   ale_nxt;
  logic       pen_r,   pen_nxt;
  logic       wrn_r,   wrn_nxt;
  logic       rdn_r,   rdn_nxt;
  logic       ctloe_r;                  // control pins driven
  logic       fault_r;                  // strap seen high
  logic       stb;                      // strobe window of a data slot

  // sequencing and pin values; pins are computed for the next phase
  // so that every output comes straight from a flip-flop
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    ack_nxt   = 1'b0;
    rspv_nxt  = 1'b0;
    rspd_nxt  = rspd_r;
    if (slot.last) begin
      if ((state_r == emb_pkg::EMB_ST_ADDR) && op_r && kind_r[1]) begin
        state_nxt = emb_pkg::EMB_ST_DATA;   // data slot drops one strobe, see R04
      end else begin
        // regular latch slot, new access taken only at a slot edge, see R03
        state_nxt = emb_pkg::EMB_ST_ADDR;
        op_nxt    = req_valid_in;
        if (req_valid_in) begin
          kind_nxt  = emb_pkg::emb_kind_e'(req_kind_in);
          addr_nxt  = req_addr_in;          // full 16-bit space, see R11
          wdata_nxt = req_wdata_in;
          ack_nxt   = 1'b1;
        end
      end
    end
    // read byte taken while the enable or read strobe is still low
    if ((slot.phase == emb_pkg::PH_SAMPLE) && op_r &&
        (((state_r == emb_pkg::EMB_ST_ADDR) && !kind_r[1]) ||
         ((state_r == emb_pkg::EMB_ST_DATA) && (kind_r == emb_pkg::EMB_K_DREAD)))) begin
      rspv_nxt = 1'b1;
      rspd_nxt = muxed_addr_data_port_in;
    end
    // latch strobe high for the first two phases of a latch slot, see R03
    ale_nxt = (state_nxt == emb_pkg::EMB_ST_ADDR) && (ph_nxt <= emb_pkg::PH_ALE_END);
    // program space only through the program enable, see R06 R11
    pen_nxt = !(op_nxt && (state_nxt == emb_pkg::EMB_ST_ADDR) && !kind_nxt[1] &&
                (ph_nxt >= emb_pkg::PH_FETCH_START) && (ph_nxt <= emb_pkg::PH_SAMPLE));
    // data space only through the port three strobes, see R10 R11
    stb     = (state_nxt == emb_pkg::EMB_ST_DATA) &&
              (ph_nxt >= emb_pkg::PH_STB_START) && (ph_nxt <= emb_pkg::PH_STB_END);
    rdn_nxt = !(stb && (kind_nxt == emb_pkg::EMB_K_DREAD));
    wrn_nxt = !(stb && (kind_nxt == emb_pkg::EMB_K_DWRITE));
    // low address first, then data on the same pins, see R01 R12
    if (state_nxt == emb_pkg::EMB_ST_ADDR) begin
      p0_nxt   = addr_nxt[7:0];
      p0oe_nxt = (ph_nxt <= emb_pkg::PH_ADDR_END);
    end else begin
      p0_nxt   = wdata_nxt;
      p0oe_nxt = (kind_nxt == emb_pkg::EMB_K_DWRITE);
    end
    // upper address for the whole access, general port otherwise, see R02
    if (op_nxt) begin
      p2_nxt   = addr_nxt[15:8];
      p2oe_nxt = 8'hff;
    end else begin
      p2_nxt   = gpio_out_in;
      p2oe_nxt = gpio_oe_in;
    end
  end

  // register only; reset releases latch strobe and enable, see R05 R07
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= emb_pkg::EMB_ST_ADDR;
      kind_r  <= emb_pkg::EMB_K_FETCH;
      op_r    <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
      ack_r   <= 1'b0;
      rspv_r  <= 1'b0;
      rspd_r  <= 8'h00;
      p0_r    <= emb_pkg::PORT_RESET;
      p0oe_r  <= 1'b0;
      p2_r    <= emb_pkg::PORT_RESET;
      p2oe_r  <= 8'h00;
      ale_r   <= 1'b1;
      pen_r   <= 1'b1;
      wrn_r   <= 1'b1;
      rdn_r   <= 1'b1;
      ctloe_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      ack_r   <= ack_nxt;
      rspv_r  <= rspv_nxt;
      rspd_r  <= rspd_nxt;
      p0_r    <= p0_nxt;
      p0oe_r  <= p0oe_nxt;
      p2_r    <= p2_nxt;
      p2oe_r  <= p2oe_nxt;
      ale_r   <= ale_nxt;
      pen_r   <= pen_nxt;
      wrn_r   <= wrn_nxt;
      rdn_r   <= rdn_nxt;
      ctloe_r <= 1'b1;
      // strap must stay low; only flagged, execution stays external, see R08
      fault_r <= external_program_select_n_in;
    end
  end

  assign req_ack_out                 = ack_r;
  assign rsp_valid_out               = rspv_r;
  assign rsp_data_out                = rspd_r;
  assign muxed_addr_data_port_out    = p0_r;
  assign muxed_addr_data_port_oe_out = p0oe_r;
  assign upper_address_port_out      = p2_r;
  assign upper_address_port_oe_out   = p2oe_r;
  assign addr_latch_out              = ale_r;
  assign addr_latch_oe_out           = ctloe_r;
  assign program_fetch_enable_n_out  = pen_r;
  assign program_fetch_enable_oe_out = ctloe_r;
  assign data_write_n_out            = wrn_r;
  assign data_read_n_out             = rdn_r;
  assign program_select_fault_out    = fault_r;

  // =========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_ALE_PERIOD: assert property ( // see R03
    $rose(ale_r) |-> ##1 ale_r ##1 !ale_r [*4] ##1 (ale_r || state_r == emb_pkg::EMB_ST_DATA))
    else $error("latch strobe period wrong");
  AST_ALE_SKIP: assert property ( // see R04
    state_r == emb_pkg::EMB_ST_DATA |-> !ale_r)
    else $error("latch strobe during data slot");
  AST_ALE_ONE_SKIP: assert property ( // see R04
    $rose(state_r == emb_pkg::EMB_ST_DATA) |-> ##6 (ale_r && state_r == emb_pkg::EMB_ST_ADDR))
    else $error("more than one latch pulse skipped");
  // the reset level of the strobe is the pull-up, not an address phase,
  // so only a driven strobe must carry the low address
  AST_P0_ADDR: assert property ( // see R01
    (ale_r && ctloe_r) |-> (p0oe_r && p0_r == addr_r[7:0]))
    else $error("low address missing under latch strobe");
  AST_WR_DATA: assert property ( // see R01
    !wrn_r |-> (p0oe_r && p0_r == wdata_r && !ale_r))
    else $error("write data missing under write strobe");
  AST_P2_ADDR: assert property ( // see R02
    op_r |-> (p2oe_r == 8'hff && p2_r == addr_r[15:8]))
    else $error("upper address missing during access");
  AST_FETCH_RSP: assert property ( // see R06
    $fell(pen_r) |-> (!kind_r[1] && !p0oe_r) ##2 rspv_r)
    else $error("program read not answered");
  AST_READ_RSP: assert property ( // see R10
    $fell(rdn_r) |-> (kind_r == emb_pkg::EMB_K_DREAD) ##4 rspv_r)
    else $error("data read not answered");
  AST_SPACES: assert property ( // see R11
    !pen_r |-> (rdn_r && wrn_r))
    else $error("program and data spaces overlap");
  // released pins must show the pull-up level, driven pins stay driven
  AST_PINS_DRIVEN: assert property ( // see R05 R07
    (ctloe_r || (ale_r && pen_r)) and
    ($past(ctloe_r) |-> (ctloe_r && addr_latch_oe_out && program_fetch_enable_oe_out)))
    else $error("control pins released outside reset");

  COV_FETCH:  cover property ($fell(pen_r) && kind_r == emb_pkg::EMB_K_FETCH);
  COV_CODE:   cover property ($fell(pen_r) && kind_r == emb_pkg::EMB_K_CODE);
  COV_DREAD:  cover property ($fell(rdn_r));
  COV_DWRITE: cover property ($fell(wrn_r));

endmodule

// File: verilog/emb_pkg.sv
// constants and types of the external memory bus block
// assumes one clock at the oscillator rate, so one slot is six clocks
package emb_pkg;

  // =========================================================
  // slot timing, counted in clock cycles
  localparam int unsigned SLOT_CLKS      = 6;    // one address-latch period
  localparam int unsigned PHASE_W        = 3;    // width of the phase count
  localparam logic [2:0]  PH_FIRST       = 3'h0; // slot start
  localparam logic [2:0]  PH_LAST        = 3'h5; // slot end
  localparam logic [2:0]  PH_ALE_END     = 3'h1; // last phase of latch strobe
  localparam logic [2:0]  PH_ADDR_END    = 3'h2; // last phase of low address
  localparam logic [2:0]  PH_FETCH_START = 3'h3; // program enable goes low
  localparam logic [2:0]  PH_SAMPLE      = 3'h4; // read data taken here
  localparam logic [2:0]  PH_STB_START   = 3'h1; // read/write strobe low
  localparam logic [2:0]  PH_STB_END     = 3'h4; // read/write strobe high after

  // =========================================================
  // reset values of the pins
  localparam logic [7:0]  PORT_RESET     = 8'hff; // ports idle high

  // =========================================================
  // access kinds; bit 1 set means data space
  typedef enum logic [1:0] {
    EMB_K_FETCH  = 2'b00,  // instruction fetch
    EMB_K_CODE   = 2'b01,  // code_table_read
    EMB_K_DREAD  = 2'b10,  // data memory read
    EMB_K_DWRITE = 2'b11   // data memory write
  } emb_kind_e;

  // slot kinds
  typedef enum logic {
    EMB_ST_ADDR = 1'b0,    // slot with a latch strobe
    EMB_ST_DATA = 1'b1     // data strobe slot, latch strobe omitted
  } emb_state_e;

endpackage

// File: verilog/emb_slot_if.sv
// phase carrier between the slot divider and the bus sequencer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface emb_slot_if;
  logic [2:0] phase;  // position inside the slot
  logic       last;   // one-cycle enable at the final phase

  modport timer (output phase, output last);
  modport user  (input phase, input last);
endinterface

// File: verilog/emb_slot_timer.sv
// divider that cuts the clock into six-cycle slots
// assumes clock_in is the oscillator and rst_in is asynchronous
`timescale 1ns/1ps
module emb_slot_timer (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // phase towards the sequencer
  emb_slot_if.timer slot
);

  // =========================================================
  // phase counter
  logic [2:0] phase_r;    // current phase
  logic [2:0] phase_nxt;  // next phase

  // wrap after the last phase, giving one slot per latch pulse
  always_comb begin
    if (phase_r == emb_pkg::PH_LAST) begin
      phase_nxt = emb_pkg::PH_FIRST;
    end else begin
      phase_nxt = phase_r + 3'h1;
    end
  end

  // register only
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign slot.phase = phase_r;
  assign slot.last  = (phase_r == emb_pkg::PH_LAST);

endmodule
